//--- rtl/aneps_page_capture.sv
// Purpose: Holds the last next page word taken from the partner
// Assumes: pageValid is a one-cycle pulse on clk from the engine
// Notes: No software path writes the held word
`timescale 1ns/10ps
`include "aneps_params.svh"

module aneps_page_capture (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Page from the negotiation engine
   input wire logic pageValid,
   input wire aneps_pkg::aneps_page_t pageWord,
   // Held page
   output aneps_pkg::aneps_page_t page
);

   aneps_pkg::aneps_cap_state_t state_q;
   aneps_pkg::aneps_cap_state_t state_d;

   // ----------------------------------------
   // Capture
   // ----------------------------------------

   // Every field follows the burst, the engine alone owns them
   always_comb begin
      state_d = state_q;
      if (pageValid) begin
         state_d.page = pageWord;
      end
   end

   // Synchronous reset clears every field
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= `ANEPS_NP_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign page = state_q.page;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   capHold_a : assert property (!pageValid |=> $stable(page))
      else $error("held page changed without a new burst");
   capTake_a : assert property (pageValid |=> page == $past(pageWord))
      else $error("held page does not match the burst");

endmodule : aneps_page_capture

//--- rtl/aneps_params.svh
// Purpose: Offsets, field positions and reset values of the status bank
// Assumes: Five-bit management register address
// Notes: Definitions only
`ifndef ANEPS_PARAMS_SVH
`define ANEPS_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ANEPS_ADDR_PARTNER_NP 5'h05
`define ANEPS_ADDR_EXPANSION 5'h06

// ----------------------------------------
// Expansion register fields
// ----------------------------------------
`define ANEPS_EXP_PDF_BIT 4
`define ANEPS_EXP_LPNP_BIT 3
`define ANEPS_EXP_LNP_BIT 2
`define ANEPS_EXP_PGRX_BIT 1
`define ANEPS_EXP_LPAN_BIT 0
`define ANEPS_EXP_RSVD_W 11

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ANEPS_NP_RESET 16'h0000
`define ANEPS_LOCAL_NP_CAPABLE 1'b1

`endif

//--- rtl/aneps_pkg.sv
// Purpose: Types shared by the status bank modules
// Assumes: Nothing beyond the params header
// Notes: Page layout follows the received link code word
package aneps_pkg;

   // ----------------------------------------
   // Received next page word
   // ----------------------------------------
   typedef struct packed {
      logic nextpageRequest;
      logic ack;
      logic messagePageFlag;
      logic complyAcknowledge;
      logic toggle;
      logic [10:0] code;
   } aneps_page_t;

   // ----------------------------------------
   // Link status levels from the negotiation engine
   // ----------------------------------------
   typedef struct packed {
      logic parallelDetectFault;
      logic partnerNextpageCapable;
      logic partnerAutonegCapable;
   } aneps_link_t;

   // State of the page capture module
   typedef struct packed {
      aneps_page_t page;
   } aneps_cap_state_t;

   // State of the register bank
   typedef struct packed {
      logic [15:0] rdata;
      aneps_link_t link;
      logic pageRx;
   } aneps_state_t;

endpackage : aneps_pkg

//--- rtl/aneps_status_bank.sv
// Purpose: Read-only next page and expansion status registers
// Assumes: Engine inputs are on clk; single register port master
// Notes: Read data stand only in the cycle after the read strobe
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "aneps_params.svh"

// Notes on behaviour
// - bit 15 shows partner wants another page
// - bit 14 shows partner acknowledged our word
// - engine updates acknowledge bit without software
// - bit 13 message page flag, resets zero
// - bit 12 partner can comply, resets zero
// - bit 11 inverted previous toggle, resets zero
// - bits 10..0 received code, reset zero
// - expansion bits 15..5 read zero, writes ignored
// - expansion bit 4 parallel detect fault
// - expansion bit 3 partner nextpage capable
// - expansion bit 2 always one
// - expansion bit 1 page received, clear-on-read
// - expansion bit 0 partner autoneg capable
module aneps_status_bank #(
   parameter int ADDR_W = 5
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdata,
   // Negotiation engine
   input wire logic pageValid,
   input wire aneps_pkg::aneps_page_t pageWord,
   input wire aneps_pkg::aneps_link_t linkStatus,
   // Status mirrors
   output logic pageReceived,
   output aneps_pkg::aneps_page_t partnerPage
);

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------

   // Address must reach both offsets
   generate
      if (ADDR_W < 3 || ADDR_W > 16) begin : g_bad_addr
         $error("ADDR_W must lie between 3 and 16");
      end
   endgenerate

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_NP = ADDR_W'(`ANEPS_ADDR_PARTNER_NP);
   localparam logic [ADDR_W-1:0] ADDR_EXP = ADDR_W'(`ANEPS_ADDR_EXPANSION);

   aneps_pkg::aneps_state_t state_q;
   aneps_pkg::aneps_state_t state_d;
   aneps_pkg::aneps_page_t page;
   logic [15:0] expValue;
   logic [15:0] npValue;
   logic rdExp;
   logic rdNp;
   logic wrAny;

   // ----------------------------------------
   // Page capture
   // ----------------------------------------
   aneps_page_capture u_capture (
      .clk(clk),
      .rst_b(rst_b),
      .pageValid(pageValid),
      .pageWord(pageWord),
      .page(page)
   );

   // ----------------------------------------
   // Address decode
   // ----------------------------------------

   // One strobe at a time, so decode needs no priority
   assign rdExp = regRd && (regAddr == ADDR_EXP);
   assign rdNp = regRd && (regAddr == ADDR_NP);
   // Writes land nowhere: both registers are read only
   assign wrAny = regWr;

   // ----------------------------------------
   // Register images
   // ----------------------------------------

   // Next page image straight from the capture, fields in word order
   assign npValue = {page.nextpageRequest,
                     page.ack,
                     page.messagePageFlag,
                     page.complyAcknowledge,
                     page.toggle,
                     page.code};

   // Expansion image, upper bits tied low so writes cannot show
   always_comb begin
      expValue = 16'h0000;
      expValue[`ANEPS_EXP_PDF_BIT] = state_q.link.parallelDetectFault;
      expValue[`ANEPS_EXP_LPNP_BIT] = state_q.link.partnerNextpageCapable;
      expValue[`ANEPS_EXP_LNP_BIT] = `ANEPS_LOCAL_NP_CAPABLE;
      expValue[`ANEPS_EXP_PGRX_BIT] = state_q.pageRx;
      expValue[`ANEPS_EXP_LPAN_BIT] = state_q.link.partnerAutonegCapable;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------

   // Link levels are sampled every cycle; the flag is sticky
   always_comb begin
      state_d = state_q;
      state_d.link = linkStatus;
      state_d.rdata = 16'h0000;
      if (rdExp) begin
         state_d.rdata = expValue;
      end else if (rdNp) begin
         state_d.rdata = npValue;
      end
      // Clear on read first, so a page in the same cycle overrides it
      if (rdExp) begin
         state_d.pageRx = 1'b0;
      end
      if (pageValid) begin
         state_d.pageRx = 1'b1;
      end
   end

   // Synchronous reset puts every field at zero
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign regRdata = state_q.rdata;
   assign pageReceived = state_q.pageRx;
   assign partnerPage = page;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Flag follows a burst in the next cycle
   pageFlagSet_a : assert property (pageValid |=> pageReceived)
      else $error("page flag not set after a burst");

   // A read without a new page empties the flag
   pageFlagClr_a : assert property (rdExp && !pageValid |=> !pageReceived)
      else $error("page flag survived its read");

   // Collision keeps the event
   pageFlagKeep_a : assert property (rdExp && pageValid |=> pageReceived)
      else $error("page lost when read and burst met");

   // Read of the flag reports it, then the next read sees it cleared
   pageFlagOnce_a : assert property (
      pageReceived && rdExp && !pageValid ##1 rdExp && !pageValid
      |=> !regRdata[`ANEPS_EXP_PGRX_BIT] ##0 $past(regRdata[`ANEPS_EXP_PGRX_BIT]))
      else $error("page flag read twice as set");

   // Reserved bits and the local capability
   expFixed_a : assert property (
      rdExp |=> regRdata[15:5] == 11'h000 && regRdata[`ANEPS_EXP_LNP_BIT])
      else $error("expansion fixed bits wrong");

   // Fault bit reflects the engine two edges earlier
   expFault_a : assert property (
      rdExp |=> regRdata[`ANEPS_EXP_PDF_BIT]
                == $past(linkStatus.parallelDetectFault, 2))
      else $error("fault bit does not follow the engine");

   // Partner next page capability
   expLpNp_a : assert property (
      rdExp |=> regRdata[`ANEPS_EXP_LPNP_BIT]
                == $past(linkStatus.partnerNextpageCapable, 2))
      else $error("partner next page bit wrong");

   // Partner negotiation capability
   expLpAn_a : assert property (
      rdExp |=> regRdata[`ANEPS_EXP_LPAN_BIT]
                == $past(linkStatus.partnerAutonegCapable, 2))
      else $error("partner negotiation bit wrong");

   // A page read right after its burst shows every field
   npFields_a : assert property (
      pageValid ##1 (rdNp && !pageValid)
      |=> regRdata == $past(pageWord, 2))
      else $error("next page fields do not match the burst");

   // Acknowledge tracks bursts even under writes
   npAckWrite_a : assert property (
      pageValid ##1 (wrAny && !pageValid)[*2]
      |=> partnerPage.ack == $past(pageWord.ack, 3))
      else $error("write disturbed the acknowledge bit");

   // Read data only in the cycle after the strobe
   rdIdle_a : assert property (!regRd |=> regRdata == 16'h0000)
      else $error("read data outside the answer cycle");

   // Unmapped addresses answer zero
   rdUnmapped_a : assert property (
      regRd && !rdExp && !rdNp |=> regRdata == 16'h0000)
      else $error("unmapped read not zero");

   // ----------------------------------------
   // Field and reset checks
   // ----------------------------------------

   // Reset empties every output; the default disable would hide this case
   resetOut_a : assert property (disable iff (1'b0)
      !rst_b |=> regRdata == 16'h0000 && !pageReceived && partnerPage == 16'h0000)
      else $error("outputs not cleared by reset");

   // Writes must not disturb anything a later read would show
   wrQuiet_a : assert property (
      regWr && !pageValid |=> $stable(partnerPage) && $stable(pageReceived))
      else $error("write changed the status image");

   // Without a page or a read of its register the flag holds
   flagSticky_a : assert property (!rdExp && !pageValid |=> $stable(pageReceived))
      else $error("page flag moved without cause");

   // The flag only ever rises after a page from the engine
   flagRise_a : assert property ($rose(pageReceived) |-> $past(pageValid))
      else $error("page flag rose without a page");

   // A read reports the flag as it stood before its own clear
   expFlagRead_a : assert property (
      rdExp |=> regRdata[`ANEPS_EXP_PGRX_BIT] == $past(pageReceived))
      else $error("flag read does not show the pre-clear value");

   // Next page read returns the held word of the strobe cycle
   npMirror_a : assert property (rdNp |=> regRdata == $past(partnerPage))
      else $error("next page read differs from the held word");

   // Each field of a fresh page lands in its own bit
   npReqField_a : assert property (
      pageValid |=> partnerPage.nextpageRequest == $past(pageWord.nextpageRequest))
      else $error("next page request bit not taken");

   npAckField_a : assert property (
      pageValid |=> partnerPage.ack == $past(pageWord.ack))
      else $error("acknowledge bit not taken");

   npMsgField_a : assert property (
      pageValid |=> partnerPage.messagePageFlag == $past(pageWord.messagePageFlag))
      else $error("message page bit not taken");

   npComply_a : assert property (
      pageValid |=> partnerPage.complyAcknowledge == $past(pageWord.complyAcknowledge))
      else $error("comply bit not taken");

   // Toggle arrives already inverted from the engine, so it is held as sent
   npToggle_a : assert property (
      pageValid |=> partnerPage.toggle == $past(pageWord.toggle))
      else $error("toggle bit not taken");

   // Code field is kept whole whatever the page type
   npCode_a : assert property (
      pageValid |=> partnerPage.code == $past(pageWord.code))
      else $error("code field not taken");

   // Scenarios worth seeing
   pageSeen_c : cover property (pageValid ##1 rdExp ##1 regRdata[1]);
   collide_c : cover property (rdExp && pageValid ##1 pageReceived);
   npRead_c : cover property (pageValid ##1 rdNp ##1 regRdata[13]);
   faultRead_c : cover property (rdExp ##1 regRdata[`ANEPS_EXP_PDF_BIT]);
   backToBack_c : cover property (rdExp ##1 rdExp);

   // Write data are not stored anywhere; keep them visible for review
   logic unusedWdata;
   assign unusedWdata = ^regWdata;

endmodule : aneps_status_bank

//--- tb/aneps_engine_model.sv
// Purpose: Stand-in for the negotiation engine feeding the status bank
// Assumes: Pages arrive as one-cycle pulses on clk
// Notes: Between pages the word lines show the inverse of the last word
`timescale 1ns/10ps

module aneps_engine_model (
   // Clock
   input wire logic clk,
   // Link levels chosen by the bench
   input wire aneps_pkg::aneps_link_t linkIn,
   // Engine outputs
   output aneps_pkg::aneps_page_t pageWord,
   output logic pageValid,
   output aneps_pkg::aneps_link_t linkStatus
);
   // Idle engine at time zero
   initial begin
      pageValid = 1'b0;
      pageWord = '0;
   end

   // Link levels pass straight through
   assign linkStatus = linkIn;

   // One page pulse, no software involved
   task automatic send_page(input aneps_pkg::aneps_page_t w);
      @(posedge clk);
      pageValid <= 1'b1;
      pageWord <= w;
      @(posedge clk);
      pageValid <= 1'b0;
      pageWord <= ~w; // Stale word must not look held
   endtask : send_page
endmodule : aneps_engine_model

//--- tb/tb_autoneg_nextpage_expansion_status.sv
// Purpose: Self-checking bench for the next page and expansion status bank
// Assumes: Read data stand only in the cycle after the read strobe
// Notes: Random pages and link levels from a fixed seed
`timescale 1ns/10ps

module tb_autoneg_nextpage_expansion_status;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] regAddr = 5'h00;
   logic [15:0] regWdata = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [15:0] regRdata;
   logic pageValid;
   logic pageReceived;
   aneps_pkg::aneps_page_t pageWord;
   aneps_pkg::aneps_page_t partnerPage;
   aneps_pkg::aneps_page_t w;
   aneps_pkg::aneps_link_t linkSt = '0;
   aneps_pkg::aneps_link_t linkStatus;
   logic [15:0] d;
   int error_cnt = 0;
   int num_checks = 0;

   // ----------------------------------------
   // Clock, design and engine
   // ----------------------------------------
   always #2 clk = ~clk;

   aneps_status_bank #(.ADDR_W(5)) i_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .pageValid(pageValid), .pageWord(pageWord), .linkStatus(linkStatus),
      .pageReceived(pageReceived), .partnerPage(partnerPage));

   aneps_engine_model i_eng (.clk(clk), .linkIn(linkSt), .pageWord(pageWord),
      .pageValid(pageValid), .linkStatus(linkStatus));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Expected expansion word; local next page capability is fixed at one
   function automatic logic [15:0] exp_val(aneps_pkg::aneps_link_t l, logic rx);
      return {11'h000, l.parallelDetectFault, l.partnerNextpageCapable, 1'b1, rx,
              l.partnerAutonegCapable};
   endfunction : exp_val

   task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk16

   task automatic chk1(input string n, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask : chk1

   // Read, then check the data fall back to zero a cycle later
   task automatic rd(input logic [4:0] a, output logic [15:0] q);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 q = regRdata;
      @(posedge clk);
      #1 chk16("rdata idle", 16'h0000, regRdata);
   endtask : rd

   // Writes are dropped; the bench still issues them to prove it
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr

   task automatic finish_test();
      if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // Watchdog: whole run is well under 2000 cycles
   // ----------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      finish_test();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(35171));
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rd(5'h05, d);
      chk16("partner np reset", 16'h0000, d);
      rd(5'h06, d);
      chk16("expansion reset", 16'h0004, d);
      rd(5'h1f, d);
      chk16("unmapped", 16'h0000, d);
      for (int i = 0; i < 24; i++) begin
         w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
         @(posedge clk);
         linkSt <= (i == 0) ? 3'b111 : (i == 1) ? 3'b000 : 3'($urandom);
         i_eng.send_page(w);
         #1 chk16("held page", w, partnerPage);
         chk1("page flag", 1'b1, pageReceived);
         wr(5'h05, ~w);
         wr(5'h06, 16'hffff);
         rd(5'h05, d);
         chk16("partner np", w, d);
         rd(5'h06, d);
         chk16("expansion set", exp_val(linkSt, 1'b1), d);
         rd(5'h06, d);
         chk16("expansion clr", exp_val(linkSt, 1'b0), d);
      end
      // Page lands on the very edge that takes the read
      fork
         i_eng.send_page(16'h2abc);
         rd(5'h06, d);
      join
      chk16("collide read", exp_val(linkSt, 1'b0), d);
      chk1("flag kept", 1'b1, pageReceived);
      rd(5'h06, d);
      chk16("flag read", exp_val(linkSt, 1'b1), d);
      // Page read on the next cycle, then the flag read twice back to back
      fork
         i_eng.send_page(16'he5a5);
         begin
            repeat (2) @(posedge clk);
            regRd <= 1'b1;
            regAddr <= 5'h05;
            @(posedge clk);
            regAddr <= 5'h06;
            #1 chk16("np next cycle", 16'he5a5, regRdata);
            @(posedge clk);
            #1 chk16("flag first read", exp_val(linkSt, 1'b1), regRdata);
            @(posedge clk);
            regRd <= 1'b0;
            #1 chk16("flag second read", exp_val(linkSt, 1'b0), regRdata);
         end
      join
      // Writes on the two cycles after a page leave the held word alone
      fork
         i_eng.send_page(16'h4123);
         begin
            repeat (2) @(posedge clk);
            regWr <= 1'b1;
            regAddr <= 5'h05;
            regWdata <= 16'hbedc;
            repeat (2) @(posedge clk);
            regWr <= 1'b0;
            @(posedge clk);
            #1 chk16("page under writes", 16'h4123, partnerPage);
         end
      join
      // Reset in mid-run with a page pending
      i_eng.send_page(16'h5123);
      @(posedge clk);
      rst_b <= 1'b0;
      linkSt <= '0;
      repeat (2) @(posedge clk);
      #1 chk16("page after reset", 16'h0000, partnerPage);
      chk1("flag after reset", 1'b0, pageReceived);
      @(posedge clk);
      rst_b <= 1'b1;
      rd(5'h06, d);
      chk16("expansion rereset", 16'h0004, d);
      finish_test();
   end
endmodule : tb_autoneg_nextpage_expansion_status
